// [rtl/logic_op_defs.svh]
// Constants of the logic-operation unit: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LOGIC_OP_DEFS_SVH
`define LOGIC_OP_DEFS_SVH

`define BUS_AW        5
`define OFS_WORK      5'h00
`define OFS_FLAGS     5'h01
`define OFS_PORT_A    5'h02
`define MEM_SEL_BIT   4
`define MEM_AW        4
`define MEM_DEPTH     16
`define FLAG_Z_BIT    0
`define FLAG_C_BIT    1
`define FLAG_AC_BIT   2
`define FLAG_OV_BIT   3
`define RST_BYTE      8'h00
`define RST_FLAGS     4'h0

`endif

// [rtl/logic_op_pkg.sv]
// Types shared by the logic-operation unit and its data memory.
// Assumes logic_op_defs.svh is on the include path.
`include "logic_op_defs.svh"

package logic_op_pkg;

  typedef struct packed {
    logic overflow_flag;
    logic aux_carry_flag;
    logic carry_flag;
    logic zero_flag;
  } flags_t;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_AND_AI,
    OP_AND_AM,
    OP_AND_MA,
    OP_OR_AI,
    OP_OR_AM,
    OP_OR_MA,
    OP_XOR_AI,
    OP_XOR_AM,
    OP_XOR_MA,
    OP_XOR_IOA,
    OP_NOT_A
  } op_t;

  typedef struct packed {
    op_t                 op;
    logic [7:0]          imm;
    logic [`MEM_AW-1:0]  addr;
  } instr_t;

  typedef enum logic {ST_IDLE, ST_EXEC} state_t;

endpackage

// [rtl/mem_byte_store.sv]
// Small byte-wide data memory with one write port and one registered read port.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "logic_op_defs.svh"

module mem_byte_store
  import logic_op_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic                we_i,
  input  wire logic [`MEM_AW-1:0]  waddr_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic [`MEM_AW-1:0]  raddr_i,
  output var  logic [7:0]          rdata_o
);

  logic [7:0] store [`MEM_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      store[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= `RST_BYTE;
    end else begin
      rdata_o <= store[raddr_i];
    end
  end

endmodule
`default_nettype wire

// [rtl/logic_op_unit.sv]
// Logic-operation unit: AND, OR, XOR and complement on the working register.
// Assumes the decoder and the register port run on REF_CLK_I; reset is synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "logic_op_defs.svh"

// Overview of operation
// RULE_01: AND with immediate puts working_register AND immediate into working_register.
// RULE_02: AND with memory combines working_register and the byte, result to register or byte.
// RULE_03: OR with immediate puts working_register OR immediate into working_register.
// RULE_04: OR with memory combines working_register and the byte, result to register or byte.
// RULE_05: XOR with immediate puts working_register XOR immediate into working_register.
// RULE_06: XOR with memory combines working_register and the byte, result to register or byte.
// RULE_07: XOR to I/O writes working_register XOR port_a_data into port_a_data, no flag moves.
// RULE_08: Complement inverts every bit of working_register in place.
// RULE_09: Complement updates zero and keeps carry, aux_carry_flag and overflow_flag.
// RULE_10: A zero update sets the flag when the 8-bit result is zero and clears it otherwise.
module logic_op_unit
  import logic_op_pkg::*;
(
  input  wire logic                REF_CLK_I,
  input  wire logic                NRST_I,
  input  wire logic                INSTR_VALID_I,
  input  wire instr_t              INSTR_I,
  input  wire logic [`BUS_AW-1:0]  ADDR_I,
  input  wire logic [7:0]          WDATA_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  output var  logic [7:0]          RDATA_O,
  output var  logic [7:0]          WORK_REG_O,
  output var  flags_t              FLAGS_O,
  output var  logic [7:0]          PORT_A_DATA_O,
  output var  logic                BUSY_O,
  output var  logic                DONE_O
);

  function automatic logic [7:0] logic_fn(input op_t op, input logic [7:0] a,
                                          input logic [7:0] b);
    case (op)
      OP_AND_AI, OP_AND_AM, OP_AND_MA:             logic_fn = a & b;
      OP_OR_AI, OP_OR_AM, OP_OR_MA:                logic_fn = a | b;
      OP_XOR_AI, OP_XOR_AM, OP_XOR_MA, OP_XOR_IOA: logic_fn = a ^ b;
      OP_NOT_A:                                    logic_fn = ~a;
      default:                                     logic_fn = a;
    endcase
  endfunction

  function automatic logic uses_mem(input op_t op);
    uses_mem = (op == OP_AND_AM) || (op == OP_AND_MA) || (op == OP_OR_AM) ||
               (op == OP_OR_MA) || (op == OP_XOR_AM) || (op == OP_XOR_MA);
  endfunction

  function automatic logic writes_mem(input op_t op);
    writes_mem = (op == OP_AND_MA) || (op == OP_OR_MA) || (op == OP_XOR_MA);
  endfunction

  state_t             state;
  state_t             next_state;
  instr_t             pend;
  instr_t             next_pend;
  logic [7:0]         work;
  logic [7:0]         next_work;
  flags_t             flags;
  flags_t             next_flags;
  logic [7:0]         port_a_data;
  logic [7:0]         next_port_a_data;
  logic [7:0]         rdata;
  logic [7:0]         next_rdata;
  logic               busy;
  logic               next_busy;
  logic               done;
  logic               next_done;
  logic               issue;
  logic [7:0]         result;
  logic               mem_we;
  logic [`MEM_AW-1:0] mem_waddr;
  logic [7:0]         mem_wdata;
  logic [7:0]         mem_rdata;

  assign issue = INSTR_VALID_I && (state == ST_IDLE);

  always_comb begin
    next_state       = state;
    next_pend        = pend;
    next_work        = work;
    next_flags       = flags;
    next_port_a_data = port_a_data;
    next_done        = 1'b0;
    next_rdata       = `RST_BYTE;
    result           = `RST_BYTE;
    mem_we           = 1'b0;
    mem_waddr        = ADDR_I[`MEM_AW-1:0];
    mem_wdata        = WDATA_I;
    // Register port; an instruction result in the same cycle overrides it
    if (WR_I) begin
      if (ADDR_I[`MEM_SEL_BIT]) begin
        mem_we = 1'b1;
      end else begin
        case (ADDR_I)
          `OFS_WORK:   next_work = WDATA_I;
          `OFS_FLAGS:  next_flags = flags_t'(WDATA_I[3:0]);
          `OFS_PORT_A: next_port_a_data = WDATA_I;
          default:     next_work = work;
        endcase
      end
    end
    if (RD_I) begin
      case (ADDR_I)
        `OFS_WORK:   next_rdata = work;
        `OFS_FLAGS:  next_rdata = {4'h0, flags};
        `OFS_PORT_A: next_rdata = port_a_data;
        default:     next_rdata = `RST_BYTE;
      endcase
    end
    case (state)
      ST_IDLE: begin
        if (issue) begin
          next_pend = INSTR_I;
          if (uses_mem(INSTR_I.op)) begin
            next_state = ST_EXEC;
          end else if (INSTR_I.op == OP_XOR_IOA) begin
            result           = logic_fn(INSTR_I.op, work, port_a_data);
            next_port_a_data = result;                          // RULE_07
            next_done        = 1'b1;
          end else if (INSTR_I.op != OP_NONE) begin
            result               = logic_fn(INSTR_I.op, work, INSTR_I.imm);
            next_work            = result;                      // RULE_01 RULE_03 RULE_05 RULE_08
            next_flags           = flags;                       // RULE_09
            next_flags.zero_flag = (result == `RST_BYTE);       // RULE_10
            next_done            = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        result               = logic_fn(pend.op, work, mem_rdata);
        next_flags           = flags;
        next_flags.zero_flag = (result == `RST_BYTE);           // RULE_10
        if (writes_mem(pend.op)) begin
          mem_we    = 1'b1;                                     // RULE_02 RULE_04 RULE_06
          mem_waddr = pend.addr;
          mem_wdata = result;
        end else begin
          next_work = result;                                   // RULE_02 RULE_04 RULE_06
        end
        next_done  = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    next_busy = (next_state == ST_EXEC);
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      state       <= ST_IDLE;
      pend        <= '0;
      work        <= `RST_BYTE;
      flags       <= flags_t'(`RST_FLAGS);
      port_a_data <= `RST_BYTE;
      rdata       <= `RST_BYTE;
      busy        <= 1'b0;
      done        <= 1'b0;
    end else begin
      state       <= next_state;
      pend        <= next_pend;
      work        <= next_work;
      flags       <= next_flags;
      port_a_data <= next_port_a_data;
      rdata       <= next_rdata;
      busy        <= next_busy;
      done        <= next_done;
    end
  end

  mem_byte_store u_mem (
    .clk_i   (REF_CLK_I),
    .nrst_i  (NRST_I),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (INSTR_I.addr),
    .rdata_o (mem_rdata)
  );

  assign RDATA_O       = rdata;
  assign WORK_REG_O    = work;
  assign FLAGS_O       = flags;
  assign PORT_A_DATA_O = port_a_data;
  assign BUSY_O        = busy;
  assign DONE_O        = done;

  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence take_s(op_t o);
    issue && (INSTR_I.op == o);
  endsequence

  sequence mem_take_s(op_t o);
    issue && (INSTR_I.op == o) ##1 (state == ST_EXEC);
  endsequence

  and_imm_a: assert property (take_s(OP_AND_AI) |=> // RULE_01
      work == ($past(work) & $past(INSTR_I.imm)) && flags.zero_flag == (work == 8'h00) &&
      flags[3:1] == $past(flags[3:1]))
    else $error("and immediate result wrong");
  or_imm_a: assert property (take_s(OP_OR_AI) |=> // RULE_03
      work == ($past(work) | $past(INSTR_I.imm)) && flags.zero_flag == (work == 8'h00) &&
      flags[3:1] == $past(flags[3:1]))
    else $error("or immediate result wrong");
  xor_imm_a: assert property (take_s(OP_XOR_AI) |=> // RULE_05
      work == ($past(work) ^ $past(INSTR_I.imm)) && flags.zero_flag == (work == 8'h00) &&
      flags[3:1] == $past(flags[3:1]))
    else $error("xor immediate result wrong");
  and_mem_a: assert property (mem_take_s(OP_AND_AM) |=> // RULE_02
      work == ($past(work) & $past(mem_rdata)) && done && flags.zero_flag == (work == 8'h00))
    else $error("and memory to register wrong");
  or_mem_a: assert property (mem_take_s(OP_OR_MA) |-> // RULE_04
      mem_we && mem_wdata == (work | mem_rdata) && mem_waddr == pend.addr ##1
      work == $past(work) && flags[3:1] == $past(flags[3:1]))
    else $error("or memory writeback wrong");
  xor_mem_a: assert property (mem_take_s(OP_XOR_MA) |-> // RULE_06
      mem_we && mem_wdata == (work ^ mem_rdata) ##1
      flags.zero_flag == ($past(mem_wdata) == 8'h00))
    else $error("xor memory writeback wrong");
  xor_port_a: assert property (take_s(OP_XOR_IOA) |=> // RULE_07
      port_a_data == ($past(work) ^ $past(port_a_data)) && flags == $past(flags) &&
      work == $past(work))
    else $error("xor to port wrong");
  not_work_a: assert property (take_s(OP_NOT_A) |=> work == ~$past(work)) // RULE_08
    else $error("complement result wrong");
  not_flags_a: assert property (take_s(OP_NOT_A) |=> // RULE_09
      flags.zero_flag == ($past(work) == 8'hFF) && flags[3:1] == $past(flags[3:1]))
    else $error("complement flags wrong");
  zero_flag_a: assert property (done && !$past(busy) && // RULE_10
      $past(INSTR_I.op) != OP_XOR_IOA |-> flags.zero_flag == (work == 8'h00))
    else $error("zero flag does not match result");

endmodule
`default_nettype wire

// [tb/tb_logic_op_unit.sv]
// Self-checking bench for the logic-operation unit: register port tasks and instruction runs.
// Assumes logic_op_pkg and logic_op_defs.svh are compiled and on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "logic_op_defs.svh"

module tb_logic_op_unit
  import logic_op_pkg::*;
;
  logic               clk;
  logic               nrst;
  logic               valid;
  instr_t             instr;
  logic [`BUS_AW-1:0] addr;
  logic [7:0]         wdata;
  logic               wr_s;
  logic               rd_s;
  logic [7:0]         rdata;
  logic [7:0]         work;
  flags_t             flags;
  logic [7:0]         port_a;
  logic               busy;
  logic               done;
  int                 miscompares;
  int                 samples_checked;

  logic_op_unit dut (
    .REF_CLK_I    (clk),
    .NRST_I       (nrst),
    .INSTR_VALID_I(valid),
    .INSTR_I      (instr),
    .ADDR_I       (addr),
    .WDATA_I      (wdata),
    .WR_I         (wr_s),
    .RD_I         (rd_s),
    .RDATA_O      (rdata),
    .WORK_REG_O   (work),
    .FLAGS_O      (flags),
    .PORT_A_DATA_O(port_a),
    .BUSY_O       (busy),
    .DONE_O       (done)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Bus write; one idle edge after so strobes never collide in one time step
  task automatic wr(input logic [`BUS_AW-1:0] a, input logic [7:0] d);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [`BUS_AW-1:0] a, input logic [7:0] exp);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge clk);
    #1;
    chk(rdata, 8'h00);
    @(posedge clk);
  endtask

  // Issue one instruction on memory byte 3 and wait for completion
  task automatic exec(input op_t op, input logic [7:0] imm, input int lat);
    int n;
    valid <= 1'b1;
    instr <= instr_t'{op, imm, 4'h3};
    @(posedge clk);
    valid <= 1'b0;
    for (n = 0; n < 4; n++) begin
      #1;
      if (n == 0) chk({7'h00, busy}, {7'h00, lat != 0});
      if (done === 1'b1) break;
      @(posedge clk);
    end
    chk(n[7:0], lat[7:0]);
    chk({7'h00, done}, 8'h01);
    @(posedge clk);
  endtask

  // Preload working register, flags (C, AC, OV set), memory byte 3 and port A, then run op
  task automatic run(input op_t op, input logic [7:0] w0, input logic [7:0] m0,
                     input logic [7:0] imm, input logic [7:0] res, input int lat);
    logic is_ma;
    logic is_io;
    is_ma = (op == OP_AND_MA) || (op == OP_OR_MA) || (op == OP_XOR_MA);
    is_io = (op == OP_XOR_IOA);
    @(posedge clk);
    wr(5'h00, w0);
    wr(5'h01, 8'h0E);
    wr(5'h13, m0);
    wr(5'h02, m0);
    exec(op, imm, lat);
    chk(work, (is_ma || is_io) ? w0 : res);
    chk({4'h0, flags}, is_io ? 8'h0E : {7'h07, res == 8'h00});
    chk(port_a, is_io ? res : m0);
    if (is_ma) begin
      wr(5'h00, 8'h00);
      exec(OP_OR_AM, 8'hFF, 1);
      chk(work, res);
    end
  endtask

  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end

  initial begin
    nrst = 1'b0;
    valid = 1'b0;
    instr = instr_t'{OP_NONE, 8'h00, 4'h0};
    addr = '0;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(5'h00, 8'h00);
    rd(5'h01, 8'h00);
    rd(5'h02, 8'h00);
    rd(5'h07, 8'h00);
    rd(5'h13, 8'h00);
    run(OP_AND_AI,  8'h3C, 8'h00, 8'h0F, 8'h0C, 0);
    run(OP_AND_AI,  8'hF0, 8'h00, 8'h0F, 8'h00, 0);
    run(OP_AND_AM,  8'h3C, 8'h0F, 8'hFF, 8'h0C, 1);
    run(OP_AND_MA,  8'h3C, 8'h0F, 8'hFF, 8'h0C, 1);
    run(OP_OR_AI,   8'h30, 8'h00, 8'h05, 8'h35, 0);
    run(OP_OR_AM,   8'h00, 8'h00, 8'hFF, 8'h00, 1);
    run(OP_OR_MA,   8'h81, 8'h18, 8'h00, 8'h99, 1);
    run(OP_XOR_AI,  8'h5A, 8'h00, 8'h5A, 8'h00, 0);
    run(OP_XOR_AM,  8'h5A, 8'hA5, 8'h00, 8'hFF, 1);
    run(OP_XOR_MA,  8'h0F, 8'h0F, 8'hFF, 8'h00, 1);
    run(OP_XOR_IOA, 8'h3C, 8'h3C, 8'hFF, 8'h00, 0);
    run(OP_XOR_IOA, 8'h3C, 8'h81, 8'h00, 8'hBD, 0);
    run(OP_NOT_A,   8'hFF, 8'h00, 8'h00, 8'h00, 0);
    run(OP_NOT_A,   8'h5A, 8'h00, 8'hFF, 8'hA5, 0);
    rd(5'h00, 8'hA5);
    wrap_up();
  end
endmodule
`default_nettype wire
